// ==== core/lrsp_pkg.sv ====
// Shared constants for the two-wire regulator slave port.
package lrsp_pkg;
  localparam logic [4:0] ADDR_FIXED = 5'h02;
  localparam logic [7:0] REG_ADDR = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int BYTE_BITS = 8;
  localparam int STRAP_BITS = 2;
  localparam int FAULT_BITS = 3;
endpackage

// ==== core/lrsp_slave.sv ====
// Two-wire slave port: control byte write, status byte read, fault release.
//
// Summary of operation
// RQ1: Both lines are released when idle; pull-ups hold them high.
// RQ2: Only the master clocks; this port never pulls the clock line.
// RQ3: Clock and data pins are open-drain: pull low or release.
// RQ4: Data changes only while clock is low, except start and stop.
// RQ5: Device pulls data low on ninth pulse after good address or data.
// RQ6: Master acknowledges the eight status bits on the ninth pulse.
// RQ7: A receiver that failed leaves data high on the ninth pulse.
// RQ8: Write acknowledges chip address, register address and control byte.
// RQ9: Read acknowledges address, register address, read address; master acks status.
// RQ10: Chip address upper five bits fixed; two low bits from strap.
// RQ11: Master sends an all-zero register address byte.
// RQ12: Start or stop anywhere restarts the transfer sequence.
// RQ13: Latched faults clear and request line releases only on master acknowledge.
// RQ14: Bytes travel most significant bit first, sampled while clock high.
// RQ15: After read address acknowledge, shift status out, then release data.
`timescale 1ns/1ps
module lrsp_slave #(
  parameter int FAULTS = lrsp_pkg::FAULT_BITS
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic [lrsp_pkg::STRAP_BITS-1:0] addr_strap_i,
  input wire logic [FAULTS-1:0] fault_i,
  input wire logic [7:0] live_status_i,
  output logic [7:0] control_o,
  output logic control_stb_o,
  output logic fault_req_n_o
);
  typedef enum {LRSP_IDLE, LRSP_ADDR, LRSP_REG, LRSP_WDATA, LRSP_RDATA, LRSP_MACK}
    lrsp_phase_e;

  typedef struct packed {
    lrsp_phase_e phase;
    logic scl_d;
    logic sda_d;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic ack_slot;
    logic ack_ok;
    logic pull_sda;
    logic [lrsp_pkg::STRAP_BITS-1:0] strap;
    logic [FAULTS-1:0] faults;
    logic [7:0] control;
    logic ctrl_stb;
    logic fault_req_n;
  } lrsp_state_s;

  lrsp_state_s q;
  lrsp_state_s next_q;
  logic [lrsp_pkg::STRAP_BITS+1:0] sync_bus;
  logic scl;
  logic sda;
  logic [lrsp_pkg::STRAP_BITS-1:0] strap_s;

  if (FAULTS < 1 || FAULTS > 8)
  begin : g_bad_faults
    $error("lrsp_slave: FAULTS must be 1 to 8.");
  end

  lrsp_sync #(
    .WIDTH(lrsp_pkg::STRAP_BITS + 2)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i({addr_strap_i, scl_i, sda_i}),
    .sync_o(sync_bus)
  );
  assign scl = sync_bus[1];
  assign sda = sync_bus[0];
  assign strap_s = sync_bus[lrsp_pkg::STRAP_BITS+1:2];

  // Compare a received address byte to this chip; bit 0 is the direction.
  function automatic logic addr_hit(input logic [7:0] b,
                                    input logic [lrsp_pkg::STRAP_BITS-1:0] s);
    addr_hit = (b[7:1] == {lrsp_pkg::ADDR_FIXED, s}); // RQ10
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] status_word;
  assign scl_rise = scl && !q.scl_d;
  assign scl_fall = !scl && q.scl_d;
  assign start_seen = scl && q.scl_d && q.sda_d && !sda;
  assign stop_seen = scl && q.scl_d && !q.sda_d && sda;
  assign status_word = live_status_i | 8'(q.faults);

  always_comb
  begin
    next_q = q;
    next_q.scl_d = scl;
    next_q.sda_d = sda;
    next_q.ctrl_stb = 1'b0;
    // Strap is re-sampled while idle so a slow analog level settles in.
    if (q.phase == LRSP_IDLE)
    begin
      next_q.strap = strap_s;
    end
    // Faults latch; a new fault in the clearing cycle still wins.
    next_q.faults = q.faults | fault_i;
    if (start_seen || stop_seen)
    begin
      next_q.phase = stop_seen ? LRSP_IDLE : LRSP_ADDR; // RQ12
      next_q.bitcnt = 4'h0;
      next_q.ack_slot = 1'b0;
      next_q.pull_sda = 1'b0; // RQ1
    end
    else if (scl_rise && q.phase != LRSP_IDLE)
    begin
      if (q.ack_slot)
      begin
        if (q.phase == LRSP_MACK && !sda)
        begin
          next_q.faults = fault_i; // RQ13
        end
      end
      else if (q.phase != LRSP_RDATA && q.phase != LRSP_MACK)
      begin
        next_q.shreg = {q.shreg[6:0], sda}; // RQ14
        next_q.bitcnt = q.bitcnt + 4'h1;
      end
      else
      begin
        next_q.bitcnt = q.bitcnt + 4'h1;
      end
    end
    else if (scl_fall && q.phase != LRSP_IDLE)
    begin
      // Every drive change except the release on start or stop happens just after a falling edge.
      next_q.pull_sda = 1'b0; // RQ4
      if (q.ack_slot)
      begin
        next_q.ack_slot = 1'b0;
        next_q.bitcnt = 4'h0;
        if (!q.ack_ok)
        begin
          next_q.phase = LRSP_IDLE; // RQ7
        end
        else
        begin
          case (q.phase)
            LRSP_ADDR:
            begin
              if (q.shreg[0])
              begin
                next_q.phase = LRSP_RDATA; // RQ15
                next_q.shreg = status_word;
                next_q.pull_sda = !status_word[7];
              end
              else
              begin
                next_q.phase = LRSP_REG;
              end
            end
            LRSP_REG: next_q.phase = LRSP_WDATA;
            LRSP_WDATA: next_q.phase = LRSP_IDLE;
            LRSP_MACK: next_q.phase = LRSP_IDLE;
            default: next_q.phase = LRSP_IDLE;
          endcase
        end
      end
      else if (q.phase == LRSP_RDATA)
      begin
        if (q.bitcnt == 4'(lrsp_pkg::BYTE_BITS))
        begin
          next_q.phase = LRSP_MACK; // RQ15
          next_q.ack_slot = 1'b1;
          next_q.ack_ok = 1'b1;
        end
        else
        begin
          next_q.shreg = {q.shreg[6:0], 1'b0};
          next_q.pull_sda = !q.shreg[6]; // RQ14
        end
      end
      else if (q.bitcnt == 4'(lrsp_pkg::BYTE_BITS))
      begin
        next_q.ack_slot = 1'b1;
        case (q.phase)
          LRSP_ADDR: next_q.ack_ok = addr_hit(q.shreg, q.strap); // RQ8 RQ9
          // Register address other than zero is refused with a high ninth bit.
          LRSP_REG: next_q.ack_ok = (q.shreg == lrsp_pkg::REG_ADDR); // RQ11
          LRSP_WDATA: next_q.ack_ok = 1'b1;
          default: next_q.ack_ok = 1'b0;
        endcase
        next_q.pull_sda = (q.phase == LRSP_ADDR) ? addr_hit(q.shreg, q.strap) :
                          (q.phase == LRSP_REG) ? (q.shreg == lrsp_pkg::REG_ADDR) :
                          1'b1; // RQ5
        if (q.phase == LRSP_WDATA)
        begin
          next_q.control = q.shreg; // RQ8
          next_q.ctrl_stb = 1'b1;
        end
      end
    end
    next_q.fault_req_n = !(|next_q.faults);
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q <= '{phase: LRSP_IDLE, scl_d: 1'b1, sda_d: 1'b1, bitcnt: 4'h0,
             shreg: 8'h00, ack_slot: 1'b0, ack_ok: 1'b0, pull_sda: 1'b0,
             strap: '0, faults: '0, control: lrsp_pkg::CTRL_RESET,
             ctrl_stb: 1'b0, fault_req_n: 1'b1};
      scl_o <= 1'b0;
      scl_oe_n_o <= 1'b1;
      sda_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
      control_o <= lrsp_pkg::CTRL_RESET;
      control_stb_o <= 1'b0;
      fault_req_n_o <= 1'b1;
    end
    else
    begin
      q <= next_q;
      scl_o <= 1'b0; // RQ3
      sda_o <= 1'b0; // RQ3
      scl_oe_n_o <= 1'b1; // RQ2
      sda_oe_n_o <= !next_q.pull_sda; // RQ3
      control_o <= next_q.control;
      control_stb_o <= next_q.ctrl_stb;
      fault_req_n_o <= next_q.fault_req_n;
    end
  end

  clock_never_driven_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    scl_oe_n_o) else $error("Clock line was driven."); // RQ2
  idle_released_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (q.phase == LRSP_IDLE) |=> ##1 sda_oe_n_o) else $error("Data held in idle."); // RQ1
  drive_when_low_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $changed(sda_oe_n_o) |-> !q.scl_d || $past(start_seen || stop_seen))
    else $error("Data drive changed with clock high."); // RQ4
  ack_pull_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    scl_fall && !q.ack_slot && q.phase == LRSP_WDATA && q.bitcnt == 4'h8 |=> ##1
    !sda_oe_n_o) else $error("Control byte not acknowledged."); // RQ5
  write_store_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    q.ctrl_stb |=> control_o == $past(q.control, 1)) else $error("Control lost."); // RQ8
  fault_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $fell(|q.faults) |-> $past(q.phase == LRSP_MACK && q.ack_slot))
    else $error("Fault cleared without acknowledge."); // RQ13
  restart_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    stop_seen |=> q.phase == LRSP_IDLE) else $error("Stop did not restart."); // RQ12
  mack_release_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    q.phase == LRSP_MACK |-> ##1 sda_oe_n_o) else $error("Data held in master ack."); // RQ15
endmodule // lrsp_slave

// ==== core/lrsp_sync.sv ====
// Two-stage synchroniser for levels entering the core clock domain.
`timescale 1ns/1ps
module lrsp_sync #(
  parameter int WIDTH = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  if (WIDTH < 1)
  begin : g_bad_width
    $error("lrsp_sync: WIDTH must be positive.");
  end
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage1 <= '1;
      sync_o <= '1;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule // lrsp_sync

// ==== verif/lnb_regulator_i2c_slave_port_bench.sv ====
// Self-checking bench for the two-wire regulator slave port.
`timescale 1ns/1ps
module lnb_regulator_i2c_slave_port_bench;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, control_stb_o, fault_req_n_o, scl_low, sda_low;
  logic [1:0] strap = 2'h0;
  logic [2:0] fault = 3'h0;
  logic [2:0] acks;
  logic [7:0] live = 8'h00;
  logic [7:0] control_o, st, q;
  logic [15:0] seed = 16'hcef5;
  int n_errors = 0;
  int check_count = 0;
  int stb_cnt = 0;
  logic [7:0] exp_ctrl[$];
  wire logic scl_w = ~scl_low & (scl_oe_n_o | scl_o);
  wire logic sda_w = ~sda_low & (sda_oe_n_o | sda_o);
  wire logic [6:0] ca = {lrsp_pkg::ADDR_FIXED, strap};
  lrsp_slave u_lrsp_slave (.core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .addr_strap_i(strap), .fault_i(fault),
    .live_status_i(live), .control_o(control_o), .control_stb_o(control_stb_o),
    .fault_req_n_o(fault_req_n_o));
  lrsp_host_model u_host (.sda_i(sda_w), .scl_low_o(scl_low), .sda_low_o(sda_low));
  initial
  begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  // Every control strobe is matched against the oldest write the bus accepted.
  always @(negedge core_clk_i)
  begin
    if (control_stb_o === 1'b1)
    begin
      stb_cnt++;
      if (exp_ctrl.size() > 0)
        check(control_o, exp_ctrl.pop_front());
      else
        check(8'(exp_ctrl.size()), 8'h01);
    end
  end
  task automatic summarize();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
    if (a == ca && r == lrsp_pkg::REG_ADDR) exp_ctrl.push_back(d);
    u_host.start_cond();
    u_host.xfer({a, 1'b0}, 1'b1, q, acks[2]);
    u_host.xfer(r, 1'b1, q, acks[1]);
    u_host.xfer(d, 1'b1, q, acks[0]);
    u_host.stop_cond();
  endtask
  task automatic rd(input logic mack);
    logic a;
    u_host.start_cond();
    u_host.xfer({ca, 1'b0}, 1'b1, q, acks[2]);
    u_host.xfer(lrsp_pkg::REG_ADDR, 1'b1, q, acks[1]);
    u_host.stop_cond();
    u_host.start_cond();
    u_host.xfer({ca, 1'b1}, 1'b1, q, acks[0]);
    u_host.xfer(8'hff, mack, st, a);
    u_host.stop_cond();
  endtask
  initial
  begin
    #200000;
    n_errors++;
    summarize();
  end
  initial
  begin
    logic [7:0] ctrl;
    logic b;
    repeat (20) @(posedge core_clk_i);
    @(negedge core_clk_i) rst_i = 1'b0;
    repeat (10) @(negedge core_clk_i);
    check(control_o, lrsp_pkg::CTRL_RESET);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      @(negedge core_clk_i) strap = i[1:0];
      repeat (8) @(negedge core_clk_i);
      wr(ca, lrsp_pkg::REG_ADDR, seed[7:0]);
      ctrl = seed[7:0];
      check({5'h00, acks}, 8'h00);
      check(control_o, ctrl);
    end
    wr({lrsp_pkg::ADDR_FIXED ^ 5'h01, strap}, lrsp_pkg::REG_ADDR, 8'h3c);
    check({5'h00, acks}, 8'h07);
    wr(ca, 8'h01, 8'h5a);
    check({5'h00, acks}, 8'h03);
    check(control_o, ctrl);
    check({6'h00, scl_oe_n_o, sda_oe_n_o}, 8'h03);
    u_host.start_cond();
    repeat (4) u_host.bit_x(1'b0, b);
    seed = lfsr(seed);
    wr(ca, lrsp_pkg::REG_ADDR, seed[7:0]);
    check({5'h00, acks}, 8'h00);
    check(control_o, seed[7:0]);
    check(stb_cnt[7:0], 8'h05);
    seed = lfsr(seed);
    @(negedge core_clk_i) live = seed[15:8];
    fault = 3'h5;
    @(negedge core_clk_i) fault = 3'h0;
    repeat (4) @(negedge core_clk_i);
    check({7'h00, fault_req_n_o}, 8'h00);
    rd(1'b1);
    check({5'h00, acks}, 8'h00);
    check(st, live | 8'h05);
    check({7'h00, fault_req_n_o}, 8'h00);
    rd(1'b0);
    check(st, live | 8'h05);
    check({7'h00, fault_req_n_o}, 8'h01);
    rd(1'b0);
    check(st, live);
    check(8'(exp_ctrl.size()), 8'h00);
    check({6'h00, scl_o, sda_o}, 8'h00);
    summarize();
  end
endmodule // lnb_regulator_i2c_slave_port_bench

// ==== verif/lrsp_host_model.sv ====
// Host bus master model that drives the clock and data lines open-drain.
`timescale 1ns/1ps
module lrsp_host_model (
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o
);
  initial
  begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // One task covers both start and repeated start, so a restart is possible mid-byte.
  task automatic start_cond();
    sda_low_o = 1'b0;
    #31 scl_low_o = 1'b0;
    #31 sda_low_o = 1'b1;
    #31 scl_low_o = 1'b1;
    #32;
  endtask
  task automatic stop_cond();
    sda_low_o = 1'b1;
    #31 scl_low_o = 1'b0;
    #31 sda_low_o = 1'b0;
    #63;
  endtask
  // Data changes only while the clock is low and is sampled in the high half.
  task automatic bit_x(input logic b, output logic r);
    sda_low_o = ~b;
    #31 scl_low_o = 1'b0;
    #31 r = sda_i;
    #31 scl_low_o = 1'b1;
    #32;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ack_in, ack);
  endtask
endmodule // lrsp_host_model
